// file: design/ssfifo_top.sv
`timescale 1ns/1ns
// Contract
// [R1] Buffer holds 512 entries: 170 three-axis sets or 128 sets with temperature.
// [R2] Policy 00 stores nothing and flushes everything held.
// [R3] Policy 01 fills until full, then drops new samples until reads free space.
// [R4] Policy 10 keeps newest samples, evicting the oldest entry when full.
// [R5] In stream policy, watermark flag raises once count reaches nine-bit threshold.
// [R6] Policy 11 captures once around activity, keeping threshold pre-event samples.
// [R7] Each entry is returned as 16 bits, low byte first then high byte.
// [R8] Bits 11..0 hold 12-bit two's complement data, bits 13..12 copy the sign.
// [R9] Bits 15..14 tag entry: 00 X, 01 Y, 10 Z, 11 temperature.
// [R10] Unlimited burst reads; bytes read while empty return 0x00.
// [R11] Host reads two bytes at a time and uses even burst lengths.
// [R12] Each set is written X, Y, Z, then optional temperature.
// [R13] With little room, only part of a set may be stored.
// [R14] Buffer indicates availability, watermark reached and overflow with loss.
// [R15] Space frees entry by entry as each word is read.
// [R16] Watermark flag holds while count at or above threshold, even zero.
// [R17] Ready flag holds while at least one entry is stored.
// [R18] Overrun sets on loss; clears on buffer reads or when disabled.
// [R19] Threshold is nine bits: watermark count low, extension bit on top.
// [R20] After trigger, store until full, then stop until policy rewritten.
module ssfifo_top
   import ssfifo_pkg::*;
#(
   parameter int DEPTH = ssfifo_pkg::SSF_DEPTH,
   parameter int AW    = ssfifo_pkg::SSF_AW
) (
   input  wire logic                     clk_sys_i,
   input  wire logic                     srst_i,
   input  wire logic                     reg_wr_i,
   input  wire logic [7:0]               reg_addr_i,
   input  wire logic [7:0]               reg_wdata_i,
   output logic      [7:0]               reg_rdata_o,
   input  wire logic                     sample_valid_i,
   input  wire ssfifo_pkg::ssf_sample_s  sample_i,
   input  wire logic                     activity_i,
   input  wire logic                     rd_byte_i,
   output logic      [7:0]               rd_byte_o,
   output ssfifo_pkg::ssf_status_s       status_o,
   output logic      [AW:0]              level_o
);
   import ssfifo_pkg::*;

   // ==========================================================
   // Registers
   logic [7:0] setup, next_setup;
   logic [7:0] wm_count, next_wm_count;
   logic       setup_wr;

   always_comb begin
      next_setup    = setup;
      next_wm_count = wm_count;
      setup_wr      = reg_wr_i && (reg_addr_i == SSF_ADDR_SETUP);
      if (setup_wr) begin
         next_setup = {4'h0, reg_wdata_i[3:0]};
      end
      if (reg_wr_i && (reg_addr_i == SSF_ADDR_WM_COUNT)) begin
         next_wm_count = reg_wdata_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         setup    <= SSF_SETUP_RESET;
         wm_count <= SSF_WM_COUNT_RESET;
      end else begin
         setup    <= next_setup;
         wm_count <= next_wm_count;
      end
   end

   always_comb begin
      case (reg_addr_i)
         SSF_ADDR_SETUP:    reg_rdata_o = setup;
         SSF_ADDR_WM_COUNT: reg_rdata_o = wm_count;
         default:           reg_rdata_o = 8'h00;
      endcase
   end

   ssf_policy_e policy;
   logic [AW:0] threshold;
   logic        with_temp;
   assign policy    = ssf_policy_e'(setup[SSF_POLICY_LSB +: 2]);
   assign with_temp = setup[SSF_TEMP_BIT];
   assign threshold = {1'b0, setup[SSF_WM_MSB_BIT], wm_count}; // [R19]

   // ==========================================================
   // Set sequencer: one entry per cycle X, Y, Z, optional T
   typedef enum {SQ_IDLE, SQ_Y, SQ_Z, SQ_T} ssf_seq_e;
   ssf_seq_e    seq, next_seq;
   ssf_sample_s hold, next_hold;
   logic [15:0] in_word;
   logic        in_valid;

   always_comb begin
      next_seq  = seq;
      next_hold = hold;
      in_valid  = 1'b0;
      in_word   = ssf_entry(SSF_TAG_X, sample_i.x); // [R8] [R9]
      case (seq) // [R12]
         SQ_IDLE: begin
            if (sample_valid_i) begin
               in_valid  = 1'b1;
               next_hold = sample_i;
               next_seq  = SQ_Y;
            end
         end
         SQ_Y: begin
            in_valid = 1'b1;
            in_word  = ssf_entry(SSF_TAG_Y, hold.y);
            next_seq = SQ_Z;
         end
         SQ_Z: begin
            in_valid = 1'b1;
            in_word  = ssf_entry(SSF_TAG_Z, hold.z);
            next_seq = with_temp ? SQ_T : SQ_IDLE;
         end
         SQ_T: begin
            in_valid = 1'b1;
            in_word  = ssf_entry(SSF_TAG_T, hold.t);
            next_seq = SQ_IDLE;
         end
         default: next_seq = SQ_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         seq  <= SQ_IDLE;
         hold <= '0;
      end else begin
         seq  <= next_seq;
         hold <= next_hold;
      end
   end

   // ==========================================================
   // Pointers, level, flags
   logic [AW-1:0] wptr, next_wptr, rptr, next_rptr;
   logic [AW:0]   count, next_count;
   logic          hi_byte, next_hi_byte;
   logic          trig_seen, next_trig_seen;
   logic          frozen, next_frozen;
   logic          ovr, next_ovr;
   logic          full, empty, wr_en, pop, evict, drop, enabled;

   assign full    = (count == (AW+1)'(DEPTH));
   assign empty   = (count == '0);
   assign enabled = (policy != SSF_DISABLED);
   // Second byte of a word releases it; an odd burst leaves the word stored
   assign pop     = rd_byte_i && hi_byte && !empty; // [R15]

   always_comb begin
      next_wptr      = wptr;
      next_rptr      = rptr;
      next_count     = count;
      next_hi_byte   = hi_byte;
      next_trig_seen = trig_seen;
      next_frozen    = frozen;
      next_ovr       = ovr;
      wr_en          = 1'b0;
      evict          = 1'b0;
      drop           = 1'b0;
      if (rd_byte_i) begin
         next_hi_byte = !hi_byte; // [R7]
      end
      case (policy)
         SSF_OLDEST: begin
            wr_en = in_valid && (!full || pop); // [R3] [R13]
            drop  = in_valid && full && !pop;
         end
         SSF_STREAM: begin
            wr_en = in_valid; // [R4]
            evict = in_valid && full && !pop;
         end
         SSF_TRIGGER: begin
            if (activity_i) begin
               next_trig_seen = 1'b1;
            end
            if (!trig_seen) begin
               // Pre-event window: keep only the newest threshold entries
               wr_en = in_valid; // [R6]
               evict = in_valid && (count >= threshold) && !pop && !empty;
               if (threshold == '0) begin
                  wr_en = 1'b0;
               end
            end else if (!frozen) begin
               wr_en = in_valid && !full; // [R20]
               // The entry that finds the buffer full is lost too, so it must flag
               drop  = in_valid && full; // [R18]
               if (in_valid && full) begin
                  next_frozen = 1'b1;
               end
            end
         end
         default: ; // [R2]
      endcase
      if (wr_en) begin
         next_wptr = wptr + 1'b1;
      end
      if (pop || evict) begin
         next_rptr = rptr + 1'b1;
      end
      next_count = count + (AW+1)'(wr_en) - (AW+1)'(pop || evict);
      // Set wins over the read clear in the same cycle
      if (drop || evict || (in_valid && frozen)) begin
         next_ovr = 1'b1; // [R18]
      end else if (rd_byte_i) begin
         next_ovr = 1'b0;
      end
      if (!enabled) begin
         next_wptr      = '0;
         next_rptr      = '0;
         next_count     = '0;
         next_hi_byte   = 1'b0;
         next_ovr       = 1'b0; // [R18]
      end
      if (setup_wr) begin
         next_trig_seen = 1'b0;
         next_frozen    = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         wptr      <= '0;
         rptr      <= '0;
         count     <= '0;
         hi_byte   <= 1'b0;
         trig_seen <= 1'b0;
         frozen    <= 1'b0;
         ovr       <= 1'b0;
      end else begin
         wptr      <= next_wptr;
         rptr      <= next_rptr;
         count     <= next_count;
         hi_byte   <= next_hi_byte;
         trig_seen <= next_trig_seen;
         frozen    <= next_frozen;
         ovr       <= next_ovr;
      end
   end

   // ==========================================================
   // Storage and byte output
   logic [15:0] head;
   logic [AW-1:0] mem_raddr;
   // Look ahead so the registered read data already shows the next head
   assign mem_raddr = next_rptr;

   ssfifo_mem #(
      .DEPTH (DEPTH),
      .AW    (AW),
      .DW    (16)
   ) u_mem ( // [R1]
      .clk_sys_i (clk_sys_i),
      .we_i      (wr_en),
      .waddr_i   (wptr),
      .wdata_i   (in_word),
      .raddr_i   (mem_raddr),
      .rdata_o   (head)
   );

   logic       bypass, next_bypass;
   logic [7:0] next_rd_byte;

   always_comb begin
      // A write to an empty buffer lands after the head read; refetch next cycle
      next_bypass = wr_en && (wptr == next_rptr);
      if (empty || bypass) begin
         next_rd_byte = SSF_EMPTY_BYTE; // [R10]
      end else begin
         next_rd_byte = hi_byte ? head[15:8] : head[7:0]; // [R7]
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         bypass <= 1'b0;
      end else begin
         bypass <= next_bypass;
      end
   end

   // Byte presented for the read strobe is taken combinationally from the head
   assign rd_byte_o = next_rd_byte;

   always_comb begin
      status_o.ready     = !empty; // [R14] [R17]
      status_o.watermark = enabled && (count >= threshold); // [R5] [R16]
      status_o.overrun   = ovr;
      level_o            = count;
   end
endmodule // ssfifo_top

// file: design/ssfifo_pkg.sv
package ssfifo_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] SSF_ADDR_SETUP     = 8'h28;
   localparam logic [7:0] SSF_ADDR_WM_COUNT  = 8'h29;
   localparam logic [7:0] SSF_SETUP_RESET    = 8'h00;
   localparam logic [7:0] SSF_WM_COUNT_RESET = 8'h80;
   localparam int         SSF_POLICY_LSB     = 0;
   localparam int         SSF_TEMP_BIT       = 2;
   localparam int         SSF_WM_MSB_BIT     = 3;
   localparam int         SSF_DEPTH          = 512;
   localparam int         SSF_AW             = 9;
   localparam logic [7:0] SSF_EMPTY_BYTE     = 8'h00;

   // ==========================================================
   // Policies and entry tags
   typedef enum logic [1:0] {
      SSF_DISABLED = 2'h0,
      SSF_OLDEST   = 2'h1,
      SSF_STREAM   = 2'h2,
      SSF_TRIGGER  = 2'h3
   } ssf_policy_e;

   typedef enum logic [1:0] {
      SSF_TAG_X = 2'h0,
      SSF_TAG_Y = 2'h1,
      SSF_TAG_Z = 2'h2,
      SSF_TAG_T = 2'h3
   } ssf_tag_e;

   typedef struct packed {
      logic [11:0] x;
      logic [11:0] y;
      logic [11:0] z;
      logic [11:0] t;
   } ssf_sample_s;

   typedef struct packed {
      logic ready;
      logic watermark;
      logic overrun;
   } ssf_status_s;

   function automatic logic [15:0] ssf_entry(input ssf_tag_e tag, input logic [11:0] d);
      return {tag, d[11], d[11], d};
   endfunction
endpackage

// file: design/ssfifo_mem.sv
`timescale 1ns/1ns
module ssfifo_mem #(
   parameter int DEPTH = 512,
   parameter int AW    = 9,
   parameter int DW    = 16
) (
   input  wire logic          clk_sys_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] waddr_i,
   input  wire logic [DW-1:0] wdata_i,
   input  wire logic [AW-1:0] raddr_i,
   output logic      [DW-1:0] rdata_o
);
   logic [DW-1:0] mem [DEPTH];

   always_ff @(posedge clk_sys_i) begin
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end
endmodule // ssfifo_mem

// file: testbench/ssfifo_sva.sv
`timescale 1ns/1ns
module ssfifo_chk
   import ssfifo_pkg::*;
#(
   parameter int DEPTH = 512,
   parameter int AW    = 9
) (
   input  wire logic                     clk_sys_i,
   input  wire logic                     srst_i,
   input  wire logic                     reg_wr_i,
   input  wire logic [7:0]               reg_addr_i,
   input  wire logic [7:0]               reg_wdata_i,
   input  wire logic                     sample_valid_i,
   input  wire logic                     rd_byte_i,
   input  wire logic [7:0]               rd_byte_o,
   input  wire ssfifo_pkg::ssf_status_s  status_o,
   input  wire logic [AW:0]              level_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   // ==========================================================
   // Shadow of the two setup registers
   logic [7:0] setup, next_setup, wm, next_wm;
   logic [8:0] thr;
   logic [1:0] pol;
   always_comb begin
      next_setup = setup;
      next_wm    = wm;
      if (srst_i) begin
         next_setup = SSF_SETUP_RESET;
         next_wm    = SSF_WM_COUNT_RESET;
      end else if (reg_wr_i && reg_addr_i == SSF_ADDR_SETUP) begin
         next_setup = reg_wdata_i;
      end else if (reg_wr_i && reg_addr_i == SSF_ADDR_WM_COUNT) begin
         next_wm = reg_wdata_i;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      setup <= next_setup;
      wm    <= next_wm;
   end
   assign thr = {setup[SSF_WM_MSB_BIT], wm};
   assign pol = setup[1:0];
   // ==========================================================
   // Sequences
   sequence s_three_up;
      level_o == $past(level_o) + 1 ##1 level_o == $past(level_o, 2) + 2 ##1 level_o == $past(level_o, 3) + 3;
   endsequence
   sequence s_quiet_read;
      !sample_valid_i [*5] ##0 (status_o.overrun && rd_byte_i);
   endsequence
   // ==========================================================
   // Properties
   chk_ready_count: assert property (status_o.ready == (level_o != 0))
      else $error("ready flag disagrees with level");
   chk_wm_thresh: assert property (pol != 2'h0 |-> status_o.watermark == (level_o >= thr))
      else $error("watermark flag disagrees with threshold");
   chk_level_cap: assert property (level_o <= DEPTH)
      else $error("level above depth");
   chk_disable_flush: assert property (reg_wr_i && reg_addr_i == SSF_ADDR_SETUP && reg_wdata_i[1:0] == 2'h0
      |-> ##[1:2] (level_o == 0 && !status_o.overrun)) else $error("disable did not flush");
   chk_empty_zero: assert property (level_o == 0 |-> rd_byte_o == SSF_EMPTY_BYTE)
      else $error("empty read not zero");
   chk_set_order: assert property (sample_valid_i && !rd_byte_i && pol == 2'h1 && level_o < 500 |=> s_three_up)
      else $error("set not stored entry per cycle");
   chk_full_drop: assert property (pol == 2'h1 && level_o == DEPTH && sample_valid_i
      |=> ##[0:3] status_o.overrun && level_o == DEPTH) else $error("full keep-oldest not dropping");
   chk_stream_evict: assert property (pol == 2'h2 && level_o == DEPTH && sample_valid_i
      |=> level_o == DEPTH [*3]) else $error("stream level left full");
   chk_read_clear: assert property (s_quiet_read |=> !status_o.overrun)
      else $error("overrun not cleared by read");
endmodule // ssfifo_chk

bind ssfifo_top ssfifo_chk #(.DEPTH(DEPTH), .AW(AW)) i_chk (
   .clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
   .reg_wdata_i(reg_wdata_i), .sample_valid_i(sample_valid_i), .rd_byte_i(rd_byte_i),
   .rd_byte_o(rd_byte_o), .status_o(status_o), .level_o(level_o));

// file: testbench/ssfifo_host.sv
`timescale 1ns/1ns
module ssfifo_host (
   input  wire logic         clk_sys_i,
   input  wire logic         srst_i,
   input  wire logic         start_i,
   input  wire logic [9:0]   words_i,
   input  wire logic         slow_i,
   input  wire logic [7:0]   byte_i,
   output logic              rd_byte_o,
   output logic [15:0]       word_o,
   output logic              word_valid_o
);
   // ==========================================================
   // Reader: whole words only, so the byte phase never drifts
   logic [10:0] left;
   logic        hi;
   logic        gap;
   logic [7:0]  lo;
   always_ff @(posedge clk_sys_i) begin
      word_valid_o <= 1'b0;
      rd_byte_o    <= 1'b0;
      gap          <= ~gap;
      if (srst_i) begin
         left <= '0;
         hi   <= 1'b0;
         gap  <= 1'b0;
      end else begin
         if (rd_byte_o) begin
            hi           <= ~hi;
            lo           <= byte_i;
            word_o       <= {byte_i, lo};
            word_valid_o <= hi;
         end
         if (start_i) begin
            left <= {words_i, 1'b0};
         end else if (left != '0 && !(slow_i && gap)) begin
            rd_byte_o <= 1'b1;
            left      <= left - 11'h1;
         end
      end
   end
endmodule // ssfifo_host

// file: testbench/tb_sensor_sample_fifo.sv
`timescale 1ns/1ns
module tb_sensor_sample_fifo;
   import ssfifo_pkg::*;
   logic        clk_sys_i = 1'b0;
   logic        srst_i = 1'b1;
   logic        reg_wr = 1'b0, smp_v = 1'b0, act = 1'b0, start = 1'b0, slow = 1'b0, rd, wv;
   logic [7:0]  addr = '0, wdat = '0, rdat, rbyte;
   logic [15:0] w;
   logic [9:0]  words = '0, lvl;
   ssf_sample_s smp = '0;
   ssf_status_s st;
   logic [15:0] m[$], exp_q[$];
   int          errors = 0, tests_run = 0, cyc = 0, pol = 0, thr = 128;
   bit          tmp = 0, trig = 0;
   integer      seed = 32'hB4E02608;
   always #5 clk_sys_i = ~clk_sys_i;
   ssfifo_top i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .reg_wr_i(reg_wr), .reg_addr_i(addr),
      .reg_wdata_i(wdat), .reg_rdata_o(rdat), .sample_valid_i(smp_v), .sample_i(smp), .activity_i(act),
      .rd_byte_i(rd), .rd_byte_o(rbyte), .status_o(st), .level_o(lvl));
   ssfifo_host i_host (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .start_i(start), .words_i(words),
      .slow_i(slow), .byte_i(rbyte), .rd_byte_o(rd), .word_o(w), .word_valid_o(wv));
   // ==========================================================
   // Tasks
   task automatic complete_run();
      $display("Checks: %0d run, %0d errors", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk_sys_i);
      reg_wr <= 1'b1;
      addr   <= a;
      wdat   <= d;
      @(posedge clk_sys_i);
      reg_wr <= 1'b0;
      if (a == SSF_ADDR_WM_COUNT) thr = {thr[8], d};
      else begin
         pol  = d[1:0];
         tmp  = d[2];
         trig = 0;
         thr  = {d[3], thr[7:0]};
         if (pol == 0) m.delete();
      end
   endtask
   task automatic rchk(logic [7:0] a, logic [7:0] e);
      @(posedge clk_sys_i);
      addr <= a;
      @(negedge clk_sys_i);
      chk("register", {8'h00, e}, {8'h00, rdat});
   endtask
   function automatic void put(logic [1:0] t, logic [11:0] d);
      logic [15:0] e;
      e = {t, d[11], d[11], d};
      if (pol == 2 && m.size() == 512) void'(m.pop_front());
      if (pol == 3 && !trig && thr != 0 && m.size() >= thr) void'(m.pop_front());
      if (m.size() < 512 && pol != 0 && !(pol == 3 && !trig && thr == 0)) m.push_back(e);
   endfunction
   task automatic send(int n);
      logic [63:0] r;
      repeat (n) begin
         r = {$random(seed), $random(seed)};
         @(posedge clk_sys_i);
         smp_v <= 1'b1;
         smp   <= r[47:0];
         put(SSF_TAG_X, r[47:36]);
         put(SSF_TAG_Y, r[35:24]);
         put(SSF_TAG_Z, r[23:12]);
         if (tmp) put(SSF_TAG_T, r[11:0]);
         @(posedge clk_sys_i);
         smp_v <= 1'b0;
         repeat (4) @(posedge clk_sys_i);
      end
   endtask
   task automatic stat(logic ov);
      @(negedge clk_sys_i);
      chk("level", 16'(m.size()), {6'h00, lvl});
      chk("ready", {15'h0000, m.size() != 0}, {15'h0000, st.ready});
      chk("watermark", {15'h0000, pol != 0 && m.size() >= thr}, {15'h0000, st.watermark});
      if (ov !== 1'bx) chk("overrun", {15'h0000, ov}, {15'h0000, st.overrun});
   endtask
   task automatic rdw(int n, bit s);
      repeat (n) exp_q.push_back(m.size() != 0 ? m.pop_front() : 16'h0000);
      @(posedge clk_sys_i);
      slow  <= s;
      start <= 1'b1;
      words <= n[9:0];
      @(posedge clk_sys_i);
      start <= 1'b0;
      while (exp_q.size() != 0) @(posedge clk_sys_i);
   endtask
   // ==========================================================
   // Watcher and hang guard
   always @(posedge clk_sys_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         complete_run();
      end
      if (wv) chk("word", exp_q.size() != 0 ? exp_q.pop_front() : 16'hXXXX, w);
   end
   initial begin
      repeat (10) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      rchk(SSF_ADDR_SETUP, 8'h00);
      rchk(SSF_ADDR_WM_COUNT, 8'h80);
      rchk(8'h2A, 8'h00);
      wr(SSF_ADDR_WM_COUNT, 8'h05);
      rchk(SSF_ADDR_WM_COUNT, 8'h05);
      wr(SSF_ADDR_SETUP, 8'h06);
      send(2);
      stat(1'b0);
      rdw(9, 1'b1);
      wr(SSF_ADDR_SETUP, 8'h05);
      send(129);
      stat(1'b1);
      rdw(513, 1'b0);
      stat(1'b0);
      wr(SSF_ADDR_SETUP, 8'h0A);
      send(172);
      stat(1'b1);
      rdw(512, 1'b1);
      send(2);
      wr(SSF_ADDR_SETUP, 8'h00);
      send(1);
      stat(1'b0);
      wr(SSF_ADDR_WM_COUNT, 8'h04);
      wr(SSF_ADDR_SETUP, 8'h03);
      send(3);
      stat(1'b1);
      // Clear overrun so the post-trigger loss has to set it again
      rdw(1, 1'b0);
      stat(1'b0);
      @(posedge clk_sys_i);
      act <= 1'b1;
      @(posedge clk_sys_i);
      act  <= 1'b0;
      trig = 1;
      send(172);
      stat(1'b1);
      rdw(512, 1'b0);
      complete_run();
   end
endmodule // tb_sensor_sample_fifo
